// [design/lra_core.sv]
// legacy register alias and legacy address generation core
`timescale 1ns/1ns
// Operation
// - packed regs 0..7 alias float regs 8..15
// - stack view index follows top of stack
// - packed read uses mantissa only
// - packed and float share one mantissa storage
// - vector n in float regs 16+2n, 17+2n
// - vector write exponent 0x1003E, sign zero
// - vector read uses both mantissas only
// - same virtual address, same physical location
// - native addresses pass unsegmented, 64 bits
// - legacy address zero-extended into region 0
// - legacy references always little-endian
// - segmentation mode from v86 flag, protection
// - data address base plus scaled index plus disp
// - truncate start; 32-bit end wraps at 4G
// - code address is sized instruction pointer
// - add segment base, wrap, limit check; the limit is checked in protected mode only
// - legacy stores into code flagged for refetch
// - detection unsure with translation mismatch
// - native side must sync caches itself
// - legacy-to-native switch flushes modified code
module lra_core
    import lra_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst,
    // native float register port
    input  wire logic                 fr_we,
    input  wire logic [FR_IDX_W-1:0]  fr_waddr,
    input  wire logic [FR_W-1:0]      fr_wdata,
    input  wire logic [FR_IDX_W-1:0]  fr_raddr,
    output logic      [FR_W-1:0]      fr_rdata,
    // legacy packed-integer port
    input  wire logic                 pk_we,
    input  wire logic [2:0]           pk_waddr,
    input  wire logic [MANT_W-1:0]    pk_wdata,
    input  wire logic [2:0]           pk_raddr,
    input  wire logic                 pk_stack_view,
    input  wire logic [2:0]           fp_top_of_stack,
    output logic      [MANT_W-1:0]    pk_rdata,
    // legacy vector port
    input  wire logic                 vec_we,
    input  wire logic [2:0]           vec_waddr,
    input  wire logic [127:0]         vec_wdata,
    input  wire logic [2:0]           vec_raddr,
    output logic      [127:0]         vec_rdata,
    // address generation
    input  wire logic                 agen_req,
    input  wire logic                 legacy_mode,
    input  wire logic                 agen_is_code,
    input  wire logic [63:0]          native_addr,
    input  wire logic                 virtual_8086_flag,
    input  wire logic                 protection_enable_bit,
    input  wire logic                 code_segment_default_size,
    input  wire logic                 stack_segment_big_bit,
    input  wire logic                 addr_size_override,
    input  wire logic                 stack_ref,
    input  wire logic [31:0]          base_reg,
    input  wire logic [31:0]          index_reg,
    input  wire logic [1:0]           index_scale,
    input  wire logic [31:0]          displacement,
    input  wire logic [31:0]          legacy_instruction_pointer,
    input  wire logic [31:0]          seg_base,
    input  wire logic [31:0]          seg_limit,
    input  wire logic [3:0]           access_len_m1,
    input  wire logic                 big_endian_cfg,
    output logic      [63:0]          va_start_ff,
    output logic      [63:0]          va_end_ff,
    output logic                      va_valid_ff,
    output logic                      little_endian_ff,
    output logic                      limit_fault_ff,
    output lra_seg_mode_t             seg_mode_ff,
    // self-modifying code tracking
    input  wire logic                 legacy_store,
    input  wire logic                 store_hits_code,
    input  wire logic                 legacy_branch,
    input  wire logic                 isa_switch_to_native,
    input  wire logic                 data_translation_enable,
    input  wire logic                 instruction_translation_enable,
    output logic                      refetch_req_ff,
    output logic                      icache_sync_ff
);

    //--------------------------------------------------------------
    // shared float register storage
    //--------------------------------------------------------------
    logic [FR_W-1:0]     fr_mem [FR_CNT];
    logic [FR_IDX_W-1:0] pk_widx;
    logic [FR_IDX_W-1:0] vec_widx;
    logic [2:0]          pk_ridx;

    assign pk_widx  = FR_IDX_W'(PK_BASE) + FR_IDX_W'(pk_waddr);
    assign vec_widx = FR_IDX_W'(VEC_BASE) + {vec_waddr, 1'b0};
    // stack view rotates by top of stack
    assign pk_ridx  = pk_stack_view ? (pk_raddr + fp_top_of_stack) : pk_raddr;

    // one storage for both views, so either side sees the other's mantissa
    // same-cycle writes to one register: vector beats packed beats native,
    // because the later statement wins; callers must not rely on a merge
    // of halves, since each writer replaces the whole 82-bit entry
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < FR_CNT; i++) fr_mem[i] <= '0;
        end else begin
            if (fr_we) fr_mem[fr_waddr] <= fr_wdata;
            if (pk_we) fr_mem[pk_widx] <= {PK_SIGN, PK_EXP, pk_wdata};
            if (vec_we) begin
                fr_mem[vec_widx]      <= {VEC_SIGN, VEC_EXP, vec_wdata[63:0]};
                fr_mem[vec_widx + 1'b1] <= {VEC_SIGN, VEC_EXP, vec_wdata[127:64]};
            end
        end
    end

    // reads registered; exponent and sign never reach the legacy views
    // a read sees storage before the edge, so a write shows up one cycle
    // later; this keeps the read path a plain flop after the array mux
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fr_rdata  <= '0;
            pk_rdata  <= '0;
            vec_rdata <= '0;
        end else begin
            fr_rdata  <= fr_mem[fr_raddr];
            pk_rdata  <= fr_mem[FR_IDX_W'(PK_BASE) + FR_IDX_W'(pk_ridx)][MANT_W-1:0];
            vec_rdata <= {fr_mem[FR_IDX_W'(VEC_BASE) + {vec_raddr, 1'b0} + 1'b1][MANT_W-1:0],
                          fr_mem[FR_IDX_W'(VEC_BASE) + {vec_raddr, 1'b0}][MANT_W-1:0]};
        end
    end

    //--------------------------------------------------------------
    // legacy effective and virtual address
    //--------------------------------------------------------------
    lra_seg_mode_t nxt_mode;
    logic          wide_ea;
    logic [31:0]   ea_raw;
    logic [31:0]   ea_start;
    logic [32:0]   ea_end16;
    logic [31:0]   va32_start;
    logic [31:0]   va32_end;
    logic [32:0]   lim_chk;

    // all of the address math is combinational and lands in one flop stage;
    // the long carry chain through base, index, displacement and segment
    // base is the price of a single-cycle answer
    always_comb begin
        // real mode without protection, v86 overrides protected
        if (!protection_enable_bit)  nxt_mode = LRA_REAL;
        else if (virtual_8086_flag)  nxt_mode = LRA_V86;
        else                         nxt_mode = LRA_PROT;
        // stack refs sized by big bit, others by code default; prefix flips data refs only, never code fetches
        wide_ea = (stack_ref && !agen_is_code ? stack_segment_big_bit : code_segment_default_size)
                  ^ (addr_size_override && !agen_is_code);
        if (nxt_mode != LRA_PROT) wide_ea = 1'b0;
        ea_raw = agen_is_code ? legacy_instruction_pointer
               : base_reg + (index_reg << index_scale) + displacement;
        ea_start = wide_ea ? ea_raw : (ea_raw & MASK16);
        // 16-bit ending address may run past 64K; 32-bit wraps
        ea_end16 = {1'b0, ea_start} + {29'h0, access_len_m1};
        va32_start = ea_start + seg_base;
        va32_end   = ea_end16[31:0] + seg_base;
        lim_chk    = wide_ea ? {1'b0, ea_start} + {29'h0, access_len_m1} : ea_end16;
    end

    // registered address result
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            va_start_ff      <= '0;
            va_end_ff        <= '0;
            va_valid_ff      <= 1'b0;
            little_endian_ff <= 1'b1;
            limit_fault_ff   <= 1'b0;
            seg_mode_ff      <= LRA_REAL;
        end else begin
            va_valid_ff <= agen_req;
            if (agen_req) begin
                if (legacy_mode) begin
                    va_start_ff      <= {REGION0_HI[63:32], va32_start};
                    va_end_ff        <= {REGION0_HI[63:32], va32_end};
                    little_endian_ff <= 1'b1;
                    limit_fault_ff   <= (nxt_mode == LRA_PROT) && (lim_chk > {1'b0, seg_limit});
                    seg_mode_ff      <= nxt_mode;
                end else begin
                    // translation downstream is shared, so equal addresses meet
                    va_start_ff      <= native_addr;
                    va_end_ff        <= native_addr + {60'h0, access_len_m1};
                    little_endian_ff <= !big_endian_cfg;
                    limit_fault_ff   <= 1'b0;
                end
            end
        end
    end

    //--------------------------------------------------------------
    // self-modifying code
    //--------------------------------------------------------------
    // detection only promised when translation enables agree
    logic smc_hit;
    logic pending_ff;
    assign smc_hit = legacy_mode && legacy_store && store_hits_code
                   && (data_translation_enable == instruction_translation_enable);

    // pending modification, set wins over clear
    // a store in the same cycle as the branch stays pending, so the
    // modified bytes are never lost between two branches
    always_ff @(posedge clk or posedge rst) begin
        if (rst) pending_ff <= 1'b0;
        else if (smc_hit) pending_ff <= 1'b1;
        else if (isa_switch_to_native || (legacy_mode && legacy_branch)) pending_ff <= 1'b0;
    end

    // refetch at the branch; native stores are not tracked
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            refetch_req_ff <= 1'b0;
            icache_sync_ff <= 1'b0;
        end else begin
            refetch_req_ff <= legacy_mode && legacy_branch && (pending_ff || smc_hit);
            icache_sync_ff <= isa_switch_to_native && (pending_ff || smc_hit);
        end
    end

    //--------------------------------------------------------------
    // checks
    //--------------------------------------------------------------
    a_legacy_region0: assert property (@(posedge clk) disable iff (rst)
        agen_req && legacy_mode |=> va_start_ff[63:32] == 32'h0 && little_endian_ff)
        else $error("legacy address left region 0");
    a_native_pass: assert property (@(posedge clk) disable iff (rst)
        agen_req && !legacy_mode |=> va_start_ff == $past(native_addr))
        else $error("native address altered");
    a_pk_fill: assert property (@(posedge clk) disable iff (rst)
        pk_we && !vec_we && !(fr_we && fr_waddr == pk_widx) ##1 fr_raddr == $past(pk_widx) && !fr_we
        |=> fr_rdata == {PK_SIGN, PK_EXP, $past(pk_wdata, 2)})
        else $error("packed write fill wrong");
    a_vec_fill: assert property (@(posedge clk) disable iff (rst)
        vec_we && !pk_we && !fr_we ##1 fr_raddr == $past(vec_widx) && !fr_we
        |=> fr_rdata == {VEC_SIGN, VEC_EXP, $past(vec_wdata[63:0], 2)})
        else $error("vector write fill wrong");
    a_mode_sel: assert property (@(posedge clk) disable iff (rst)
        agen_req && legacy_mode && !protection_enable_bit |=> seg_mode_ff == LRA_REAL)
        else $error("segmentation mode wrong");
    a_trunc16: assert property (@(posedge clk) disable iff (rst)
        agen_req && legacy_mode && !protection_enable_bit && seg_base == 32'h0
        |=> va_start_ff[31:16] == 16'h0)
        else $error("16-bit start not truncated");
    // store, one quiet cycle, then the switch: the sync must follow
    a_smc_sync: assert property (@(posedge clk) disable iff (rst)
        smc_hit ##1 (!legacy_branch && !isa_switch_to_native)
        ##1 isa_switch_to_native |=> icache_sync_ff)
        else $error("switch did not sync");
    // store, one quiet cycle, then a legacy branch: refetch must follow
    a_refetch: assert property (@(posedge clk) disable iff (rst)
        smc_hit ##1 (!legacy_branch && !isa_switch_to_native)
        ##1 (legacy_mode && legacy_branch) |=> refetch_req_ff)
        else $error("modified code not refetched");
    // every request leaves a valid behind it
    a_valid_copy: assert property (@(posedge clk) disable iff (rst)
        agen_req |=> va_valid_ff)
        else $error("address valid missing");
    // native references never see a segment limit
    a_native_nofault: assert property (@(posedge clk) disable iff (rst)
        agen_req && !legacy_mode |=> !limit_fault_ff)
        else $error("native reference faulted");
    // limit checks belong to protected mode only
    a_real_nofault: assert property (@(posedge clk) disable iff (rst)
        agen_req && legacy_mode && nxt_mode != LRA_PROT |=> !limit_fault_ff)
        else $error("limit fault outside protected mode");
    // v86 flag wins once protection is on
    a_v86_mode: assert property (@(posedge clk) disable iff (rst)
        agen_req && legacy_mode && protection_enable_bit && virtual_8086_flag |=> seg_mode_ff == LRA_V86)
        else $error("v86 mode not selected");
    // the ending byte stays in region 0 as well
    a_end_region0: assert property (@(posedge clk) disable iff (rst)
        agen_req && legacy_mode |=> va_end_ff[63:32] == 32'h0)
        else $error("legacy end address left region 0");
    // instruction fetches are little-endian as well as data
    a_code_le: assert property (@(posedge clk) disable iff (rst)
        agen_req && legacy_mode && agen_is_code |=> little_endian_ff)
        else $error("legacy fetch not little-endian");
    // mismatched translation enables leave the tracker idle
    a_xlate_skip: assert property (@(posedge clk) disable iff (rst)
        legacy_store && store_hits_code && !pending_ff
        && data_translation_enable != instruction_translation_enable |=> !pending_ff)
        else $error("store tracked with mismatched translation");
    // a refetch is only ever caused by a branch
    a_refetch_cause: assert property (@(posedge clk) disable iff (rst)
        refetch_req_ff |-> $past(legacy_branch))
        else $error("refetch without branch");
    // a sync is only ever caused by a switch to native
    a_sync_cause: assert property (@(posedge clk) disable iff (rst)
        icache_sync_ff |-> $past(isa_switch_to_native))
        else $error("sync without switch");
    c_pk_write:  cover property (@(posedge clk) pk_we);
    c_vec_write: cover property (@(posedge clk) vec_we);
    c_prot_agen: cover property (@(posedge clk) agen_req && legacy_mode && protection_enable_bit);
    c_smc_sync:  cover property (@(posedge clk) icache_sync_ff);
    c_refetch:   cover property (@(posedge clk) refetch_req_ff);

endmodule // lra_core

// [dv/lra_pipe_model.sv]
// pipeline model: legacy store into code, then a branch or a switch to native
`timescale 1ns/1ns
module lra_pipe_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic go,
    input  wire logic use_switch,
    input  wire logic bad_xlate,
    output logic      legacy_store,
    output logic      store_hits_code,
    output logic      legacy_branch,
    output logic      isa_switch_to_native,
    output logic      data_translation_enable,
    output logic      instruction_translation_enable
);
    // ----------------------------------------
    // sequence: store, gap, branch or switch
    // ----------------------------------------
    logic [1:0] step_ff;
    // steps 1..3 run once per go, then wrap to idle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            step_ff <= 2'h0;
        end else if (go || step_ff != 2'h0) begin
            step_ff <= step_ff + 2'h1;
        end
    end
    // stores come only from the legacy side, never from native code
    assign legacy_store                   = (step_ff == 2'h1);
    assign store_hits_code                = (step_ff == 2'h1);
    assign legacy_branch                  = (step_ff == 2'h3) && !use_switch;
    assign isa_switch_to_native           = (step_ff == 2'h3) && use_switch;
    // enables differ only when a test asks for it
    assign data_translation_enable        = 1'h1;
    assign instruction_translation_enable = !bad_xlate;
endmodule // lra_pipe_model

// [dv/tb.sv]
// self-checking testbench for the register alias and address generator
`timescale 1ns/1ns
module tb
    import lra_pkg::*;
;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic              clk, rst, fr_we, pk_we, pk_stack_view, vec_we, agen_req, legacy_mode, agen_is_code;
    logic              virtual_8086_flag, protection_enable_bit, code_segment_default_size;
    logic              stack_segment_big_bit, addr_size_override, stack_ref, big_endian_cfg, go, use_switch;
    logic              bad_xlate, va_valid_ff, little_endian_ff, limit_fault_ff, refetch_req_ff;
    logic              icache_sync_ff, legacy_store, store_hits_code, legacy_branch, isa_switch_to_native;
    logic              data_translation_enable, instruction_translation_enable;
    logic [4:0]        fr_waddr, fr_raddr;
    logic [FR_W-1:0]   fr_wdata, fr_rdata;
    logic [2:0]        pk_waddr, pk_raddr, fp_top_of_stack, vec_waddr, vec_raddr;
    logic [63:0]       pk_wdata, pk_rdata, native_addr, va_start_ff, va_end_ff;
    logic [127:0]      vec_wdata, vec_rdata;
    logic [31:0]       base_reg, index_reg, displacement, legacy_instruction_pointer, seg_base, seg_limit;
    logic [1:0]        index_scale;
    logic [3:0]        access_len_m1;
    lra_seg_mode_t     seg_mode_ff;
    int                miscompares, n_checks;

    lra_core u_dut (.clk, .rst, .fr_we, .fr_waddr, .fr_wdata, .fr_raddr, .fr_rdata, .pk_we, .pk_waddr,
        .pk_wdata, .pk_raddr, .pk_stack_view, .fp_top_of_stack, .pk_rdata, .vec_we, .vec_waddr, .vec_wdata,
        .vec_raddr, .vec_rdata, .agen_req, .legacy_mode, .agen_is_code, .native_addr, .virtual_8086_flag,
        .protection_enable_bit, .code_segment_default_size, .stack_segment_big_bit, .addr_size_override,
        .stack_ref, .base_reg, .index_reg, .index_scale, .displacement, .legacy_instruction_pointer,
        .seg_base, .seg_limit, .access_len_m1, .big_endian_cfg, .va_start_ff, .va_end_ff, .va_valid_ff,
        .little_endian_ff, .limit_fault_ff, .seg_mode_ff, .legacy_store, .store_hits_code, .legacy_branch,
        .isa_switch_to_native, .data_translation_enable, .instruction_translation_enable, .refetch_req_ff,
        .icache_sync_ff);
    lra_pipe_model u_pipe (.clk, .rst, .go, .use_switch, .bad_xlate, .legacy_store, .store_hits_code,
        .legacy_branch, .isa_switch_to_native, .data_translation_enable, .instruction_translation_enable);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    always #5 clk = ~clk;
    task automatic tick; @(posedge clk); endtask
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one address request; outputs are looked at one cycle later
    task automatic fire; agen_req <= 1'h1; tick; agen_req <= 1'h0; #1; endtask
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_pk;
        tick; pk_we <= 1'h1; pk_waddr <= 3'h3; pk_wdata <= 64'h0123456789abcdef; fr_raddr <= 5'hb; pk_raddr <= 3'h3;
        tick; pk_we <= 1'h0; tick; #1;
        chk(fr_rdata, {1'h1, 17'h1ffff, 64'h0123456789abcdef});
        chk(pk_rdata, 64'h0123456789abcdef);
        // float write with foreign sign and exponent, read through the stack view: (2+5) mod 8 = 7
        fr_we <= 1'h1; fr_waddr <= 5'hf; fr_wdata <= {1'h0, 17'h0, 64'hfeedface00c0ffee};
        pk_stack_view <= 1'h1; fp_top_of_stack <= 3'h5; pk_raddr <= 3'h2;
        tick; fr_we <= 1'h0; tick; #1;
        chk(pk_rdata, 64'hfeedface00c0ffee);
        $display("test packed done");
    endtask
    task automatic t_vec;
        vec_we <= 1'h1; vec_waddr <= 3'h7; vec_wdata <= {64'haaaa0000bbbb1111, 64'h5555cccc6666dddd};
        fr_raddr <= 5'h1e; tick; vec_we <= 1'h0; tick; #1;
        chk(fr_rdata, {1'h0, 17'h1003e, 64'h5555cccc6666dddd});
        fr_raddr <= 5'h1f; tick; #1;
        chk(fr_rdata, {1'h0, 17'h1003e, 64'haaaa0000bbbb1111});
        fr_we <= 1'h1; fr_waddr <= 5'h1f; fr_wdata <= {1'h1, 17'h1ffff, 64'h1111111111111111}; vec_raddr <= 3'h7;
        tick; fr_we <= 1'h0; tick; #1;
        chk(vec_rdata, {64'h1111111111111111, 64'h5555cccc6666dddd});
        $display("test vector done");
    endtask
    task automatic t_agen;
        legacy_mode <= 1'h1; protection_enable_bit <= 1'h1; code_segment_default_size <= 1'h1;
        big_endian_cfg <= 1'h1;
        base_reg <= 32'hffffff00; index_reg <= 32'h4; index_scale <= 2'h2; displacement <= 32'he0;
        seg_base <= 32'hc; seg_limit <= 32'hffffffff; access_len_m1 <= 4'h7;
        fire; chk(va_start_ff, 64'hfffffffc);
        chk(va_end_ff, 64'h3);
        chk(little_endian_ff, 1'h1);
        chk(seg_mode_ff, LRA_PROT);
        chk({va_valid_ff, limit_fault_ff}, 2'h2);
        seg_limit <= 32'hfffffff6; fire; chk(limit_fault_ff, 1'h1);
        stack_ref <= 1'h1; fire; chk({va_start_ff, va_end_ff}, {64'hfffc, 64'h10003});
        addr_size_override <= 1'h1; fire; chk(va_start_ff, 64'hfffffffc);
        {protection_enable_bit, stack_ref, addr_size_override} <= 3'h0;
        base_reg <= 32'h1fff0; index_reg <= 32'h0; displacement <= 32'hc; seg_base <= 32'h10000;
        fire; chk({va_start_ff, va_end_ff}, {64'h1fffc, 64'h20003});
        chk(seg_mode_ff, LRA_REAL);
        {protection_enable_bit, virtual_8086_flag} <= 2'h3; fire; chk(seg_mode_ff, LRA_V86);
        virtual_8086_flag <= 1'h0; agen_is_code <= 1'h1; code_segment_default_size <= 1'h0;
        addr_size_override <= 1'h1; legacy_instruction_pointer <= 32'h12345; seg_base <= 32'h0;
        fire; chk({va_start_ff, va_end_ff}, {64'h2345, 64'h234c});
        legacy_mode <= 1'h0; native_addr <= 64'hfedcba9876543210;
        fire; chk(va_start_ff, 64'hfedcba9876543210);
        chk({va_end_ff, limit_fault_ff}, {64'hfedcba9876543217, 1'h0});
        $display("test agen done");
    endtask
    task automatic smc(input logic sw, input logic bad, input logic er, input logic es);
        legacy_mode <= 1'h1; use_switch <= sw; bad_xlate <= bad; go <= 1'h1;
        tick; go <= 1'h0; repeat (3) tick; #1;
        chk({refetch_req_ff, icache_sync_ff}, {er, es});
        tick; #1; chk({refetch_req_ff, icache_sync_ff}, 2'h0);
        $display("test smc done");
    endtask

    initial begin
        {clk, fr_we, pk_we, pk_stack_view, vec_we, agen_req, legacy_mode, agen_is_code, virtual_8086_flag,
         protection_enable_bit, code_segment_default_size, stack_segment_big_bit, addr_size_override,
         stack_ref, big_endian_cfg, go, use_switch, bad_xlate, fr_waddr, fr_raddr, fr_wdata, pk_waddr,
         pk_raddr, fp_top_of_stack, vec_waddr, vec_raddr, pk_wdata, native_addr, vec_wdata, base_reg,
         index_reg, displacement, legacy_instruction_pointer, seg_base, seg_limit, index_scale,
         access_len_m1, miscompares, n_checks} = '0;
        rst = 1'h1;
        repeat (20) tick;
        rst <= 1'h0;
        t_pk; t_vec; t_agen;
        smc(1'h0, 1'h0, 1'h1, 1'h0);
        smc(1'h1, 1'h0, 1'h0, 1'h1);
        smc(1'h0, 1'h1, 1'h0, 1'h0);
        final_report;
    end
    // watchdog well beyond the fewer than 60 cycles the tests need
    initial begin
        #20000;
        miscompares++;
        final_report;
    end
endmodule // tb

// [shared/lra_pkg.sv]
// package of constants and types for the legacy register alias and address generator
package lra_pkg;
    localparam int FR_W          = 82;       // floating register width
    localparam int MANT_W        = 64;
    localparam int EXP_LSB       = 64;
    localparam int EXP_MSB       = 80;
    localparam int SIGN_BIT      = 81;
    localparam int FR_CNT        = 32;
    localparam int FR_IDX_W      = 5;
    localparam int PK_BASE       = 8;        // packed reg 0 lives here
    localparam int VEC_BASE      = 16;       // vector reg 0 low half lives here
    localparam logic [16:0] PK_EXP   = 17'h1ffff;
    localparam logic        PK_SIGN  = 1'b1;
    localparam logic [16:0] VEC_EXP  = 17'h1003e;
    localparam logic        VEC_SIGN = 1'b0;
    localparam logic [31:0] MASK16   = 32'h0000ffff;
    localparam logic [63:0] REGION0_HI = 64'h0;
    typedef enum logic [1:0] {LRA_REAL, LRA_V86, LRA_PROT} lra_seg_mode_t;
    typedef enum {LRA_NATIVE, LRA_LEGACY} lra_isa_t;
endpackage
